// ==== hdl/tim_monitor.sv ====
// Behaviour
// - Both low: trip, no start, status on.
// - Both high: run permitted, status off.
// - One high: trip, no start, status off.
// - Opposite channel states form the discrepancy.
// - Discrepancy beyond maximum time locks fault.
// - Short discrepancy never faults; typical threshold between.
// - Lock occurs on expiry without input change.
// - Locked: tripped, no start, status off.
// - Only full power cycle leaves lock.
// - Status on only in safe state.
// - Status follows inputs on auxiliary power.
// - Ignore low test pulses under 2 ms.
// - Low must persist filter time first.
//
// Top of the dual-channel torque-inhibit monitor.
// Assumes channel inputs synchronous to sys_clk; reset is the power-on reset,
// raised only by a full power cycle including the auxiliary supply.
`timescale 1ns/1ps
`default_nettype none
module tim_monitor #(
	parameter int unsigned FILT_CYC = tim_pkg::LOW_FILTER_CYC,
	parameter int unsigned TRIP_CYC = tim_pkg::DISC_TRIP_CYC
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic channel_a_inhibit_in,
	input wire logic channel_b_inhibit_in,
	input wire logic sw_run_request,
	output logic run_permit,
	output logic motor_power_en,
	output logic torque_inhibit_trip,
	output logic locked_fault,
	output logic inhibit_status_pos,
	output logic inhibit_status_neg
);
	tim_pkg::tim_chan_s chan;
	tim_pkg::tim_state_e state_ff;
	tim_pkg::tim_state_e nxt_state;
	tim_pkg::tim_out_s out_ff;
	tim_pkg::tim_out_s nxt_out;
	logic motor_ff;
	logic status_neg_ff;
	logic disagree;
	logic expired;
	logic [1:0] raw_chan;
	logic [1:0] filt_chan;

	// Channel A on bit 1, channel B on bit 0, matching the carrier
	assign raw_chan = {channel_a_inhibit_in, channel_b_inhibit_in};

	// Per-channel low filters
	for (genvar gi = 0; gi < 2; gi++) begin : g_filt
		tim_low_filter #(.FILT_CYC(FILT_CYC)) u_filt (
			.sys_clk(sys_clk),
			.reset(reset),
			.raw_in(raw_chan[gi]),
			.filt_out(filt_chan[gi])
		);
	end

	assign chan = tim_pkg::tim_chan_s'(filt_chan);

	// Discrepancy is opposite channel states
	assign disagree = chan.chan_a ^ chan.chan_b;

	tim_disc_timer #(.TRIP_CYC(TRIP_CYC)) u_timer (
		.sys_clk(sys_clk),
		.reset(reset),
		.disagree(disagree),
		.expired(expired)
	);

	// State decode from filtered channels; lock is absorbing
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			tim_pkg::TIM_LOCKED: begin
				nxt_state = tim_pkg::TIM_LOCKED;
			end
			tim_pkg::TIM_SAFE, tim_pkg::TIM_RUN, tim_pkg::TIM_DISAGREE: begin
				if (expired) begin
					nxt_state = tim_pkg::TIM_LOCKED;
				end else if (disagree) begin
					nxt_state = tim_pkg::TIM_DISAGREE;
				end else if (chan.chan_a) begin
					nxt_state = tim_pkg::TIM_RUN;
				end else begin
					nxt_state = tim_pkg::TIM_SAFE;
				end
			end
			default: begin
				nxt_state = tim_pkg::TIM_LOCKED;
			end
		endcase
	end

	// State register, power-on reset returns to input-driven state
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_ff <= tim_pkg::TIM_SAFE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Output decode from the next state so outputs track it with no lag
	always_comb begin
		nxt_out = '0;
		case (nxt_state)
			tim_pkg::TIM_SAFE: begin
				nxt_out.trip = 1'b1;
				nxt_out.status_on = 1'b1;
			end
			tim_pkg::TIM_RUN: begin
				nxt_out.run_permit = 1'b1;
			end
			tim_pkg::TIM_DISAGREE: begin
				nxt_out.trip = 1'b1;
			end
			tim_pkg::TIM_LOCKED: begin
				nxt_out.trip = 1'b1;
				nxt_out.locked_fault = 1'b1;
			end
			default: begin
				nxt_out.trip = 1'b1;
			end
		endcase
	end

	// Registered outputs; safe state at reset
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			out_ff <= '{run_permit: 1'b0, trip: 1'b1, status_on: 1'b1, locked_fault: 1'b0};
		end else begin
			out_ff <= nxt_out;
		end
	end

	// Motor power only with permission and a software run request
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			motor_ff <= 1'b0;
		end else begin
			motor_ff <= nxt_out.run_permit && sw_run_request;
		end
	end

	// Inverse status leg kept in its own flop so the pin is registered
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			status_neg_ff <= 1'b0;
		end else begin
			status_neg_ff <= ~nxt_out.status_on;
		end
	end

	assign run_permit = out_ff.run_permit;
	assign torque_inhibit_trip = out_ff.trip;
	assign locked_fault = out_ff.locked_fault;
	assign inhibit_status_pos = out_ff.status_on;
	assign inhibit_status_neg = status_neg_ff;
	assign motor_power_en = motor_ff;
endmodule // tim_monitor
`default_nettype wire

// ==== hdl/tim_pkg.sv ====
// Package for the dual-channel torque-inhibit monitor: timing, states and carriers.
// Assumes a 50 MHz system clock; nothing else.
package tim_pkg;

	// System clock rate
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned CLK_KHZ = 50_000;

	// Discrepancy detection limits, in milliseconds as printed
	localparam int unsigned DISC_MIN_MS = 1600;
	localparam int unsigned DISC_TYP_MS = 2300;
	localparam int unsigned DISC_MAX_MS = 3000;
	// Typical threshold chosen as the trip point, in cycles
	localparam int unsigned DISC_TRIP_CYC = DISC_TYP_MS * CLK_KHZ;
	localparam int unsigned DISC_MIN_CYC = DISC_MIN_MS * CLK_KHZ;
	localparam int unsigned DISC_MAX_CYC = DISC_MAX_MS * CLK_KHZ;

	// Low-level filter: pulses under 2 ms ignored, 6 ms typical to act
	localparam int unsigned PULSE_IGNORE_US = 2000;
	localparam int unsigned LOW_FILTER_US = 6000;
	localparam int unsigned LOW_FILTER_CYC = LOW_FILTER_US * (CLK_KHZ / 1000);
	localparam int unsigned PULSE_IGNORE_CYC = PULSE_IGNORE_US * (CLK_KHZ / 1000);

	// Monitor states
	typedef enum logic [1:0] {
		TIM_SAFE,
		TIM_RUN,
		TIM_DISAGREE,
		TIM_LOCKED
	} tim_state_e;

	// Filtered channel pair
	typedef struct packed {
		logic chan_a;
		logic chan_b;
	} tim_chan_s;

	// Outputs toward the drive
	typedef struct packed {
		logic run_permit;
		logic trip;
		logic status_on;
		logic locked_fault;
	} tim_out_s;

endpackage

// ==== hdl/tim_low_filter.sv ====
// Low-going glitch filter for one channel input.
// Assumes the input is already synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module tim_low_filter #(
	parameter int unsigned FILT_CYC = tim_pkg::LOW_FILTER_CYC
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic raw_in,
	output logic filt_out
);
	localparam int unsigned CW = $clog2(FILT_CYC + 1);
	logic [CW-1:0] low_cnt_ff;
	logic filt_ff;

	// Count consecutive low cycles; any high restarts the count
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			low_cnt_ff <= '0;
		end else if (raw_in) begin
			low_cnt_ff <= '0;
		end else if (low_cnt_ff != CW'(FILT_CYC)) begin
			low_cnt_ff <= low_cnt_ff + CW'(1);
		end
	end

	// High follows at once, low only after a full filter time
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			filt_ff <= 1'b0;
		end else if (raw_in) begin
			filt_ff <= 1'b1;
		end else if (low_cnt_ff == CW'(FILT_CYC - 1)) begin
			filt_ff <= 1'b0;
		end
	end

	assign filt_out = filt_ff;
endmodule // tim_low_filter
`default_nettype wire

// ==== hdl/tim_disc_timer.sv ====
// Discrepancy duration counter with terminal level, held while disagreement lasts.
// Assumes disagree is a filtered level synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module tim_disc_timer #(
	parameter int unsigned TRIP_CYC = tim_pkg::DISC_TRIP_CYC
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic disagree,
	output logic expired
);
	localparam int unsigned CW = $clog2(TRIP_CYC + 1);
	logic [CW-1:0] cnt_ff;
	logic exp_ff;

	// Count while channels disagree, clear on agreement
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cnt_ff <= '0;
		end else if (!disagree) begin
			cnt_ff <= '0;
		end else if (cnt_ff != CW'(TRIP_CYC)) begin
			cnt_ff <= cnt_ff + CW'(1);
		end
	end

	// Expiry level once the terminal count is reached
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			exp_ff <= 1'b0;
		end else begin
			exp_ff <= disagree && (cnt_ff >= CW'(TRIP_CYC - 1));
		end
	end

	assign expired = exp_ff;
endmodule // tim_disc_timer
`default_nettype wire

// ==== dv/tim_safety_ctrl.sv ====
// Model of the external safety controller driving both channels.
// Assumes commands change at the falling edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module tim_safety_ctrl #(
	parameter int SKEW = 2
) (
	input wire logic sys_clk,
	input wire logic cmd_a,
	input wire logic cmd_b,
	input wire logic pulse_a,
	output logic chan_a,
	output logic chan_b
);
	logic [7:0] b_dly_ff = '0;
	// Channel B lags A by a short relay skew
	always @(posedge sys_clk) begin
		b_dly_ff <= {b_dly_ff[6:0], cmd_b};
	end
	// Low test pulse on channel A
	assign chan_a = cmd_a & ~pulse_a;
	assign chan_b = b_dly_ff[SKEW-1];
endmodule // tim_safety_ctrl
`default_nettype wire

// ==== dv/tim_monitor_sva.sv ====
// Port checker for the torque-inhibit monitor.
// Assumes small filter and trip counts (4 and 20).
`timescale 1ns/1ps
`default_nettype none
module tim_monitor_sva (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic channel_a_inhibit_in,
	input wire logic channel_b_inhibit_in,
	input wire logic run_permit,
	input wire logic motor_power_en,
	input wire logic torque_inhibit_trip,
	input wire logic locked_fault,
	input wire logic inhibit_status_pos,
	input wire logic inhibit_status_neg
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	int dcnt_ff;
	// Length of raw disagreement
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			dcnt_ff <= 0;
		else
			dcnt_ff <= (channel_a_inhibit_in != channel_b_inhibit_in) ? dcnt_ff + 1 : 0;
	end
	sequence both_high_s;
		channel_a_inhibit_in && channel_b_inhibit_in && !locked_fault;
	endsequence
	run_when_high_a: assert property (both_high_s [*3] |=> run_permit) else $error("no run");
	low_stops_a: assert property ((!channel_a_inhibit_in) [*7] |-> !run_permit) else $error("low ignored");
	pulse_free_a: assert property ($fell(run_permit) && !locked_fault |->
		!$past(channel_a_inhibit_in, 4) || !$past(channel_b_inhibit_in, 4)) else $error("early drop");
	lock_due_a: assert property (dcnt_ff == 32 |-> locked_fault) else $error("no lock");
	lock_hold_a: assert property (locked_fault |=> locked_fault && !run_permit && !inhibit_status_pos)
		else $error("lock lost");
	status_pair_a: assert property (inhibit_status_neg != inhibit_status_pos) else $error("status pair");
	status_safe_a: assert property (inhibit_status_pos |-> !run_permit && !locked_fault) else $error("status on");
	trip_run_a: assert property (torque_inhibit_trip != run_permit) else $error("trip mismatch");
	motor_gate_a: assert property (motor_power_en |-> run_permit) else $error("motor on");
endmodule // tim_monitor_sva
bind tim_monitor tim_monitor_sva u_sva (.*);
`default_nettype wire

// ==== dv/tim_monitor_bench.sv ====
// Self-checking bench for the torque-inhibit monitor.
// Assumes filter count 4 and trip count 20.
`timescale 1ns/1ps
`default_nettype none
module tim_monitor_bench;
	localparam int FC = 4;
	localparam int TC = 20;
	logic sys_clk = 0, reset = 1, cmd_a = 0, cmd_b = 0, pulse_a = 0, sw_run_request = 0;
	logic channel_a_inhibit_in, channel_b_inhibit_in, run_permit, motor_power_en;
	logic torque_inhibit_trip, locked_fault, inhibit_status_pos, inhibit_status_neg;
	logic [5:0] o;
	int error_cnt = 0, n_compared = 0;
	// Rows: a, b, sw request, then run, motor, trip, status
	logic [6:0] rows [7] = '{7'b000_0011, 7'b110_1000, 7'b111_1100, 7'b101_0010,
		7'b001_0011, 7'b011_0010, 7'b000_0011};
	assign o = {run_permit, motor_power_en, torque_inhibit_trip, locked_fault, inhibit_status_pos, inhibit_status_neg};
	tim_monitor #(.FILT_CYC(FC), .TRIP_CYC(TC)) DUT (.*);
	tim_safety_ctrl ctrl (.sys_clk(sys_clk), .cmd_a(cmd_a), .cmd_b(cmd_b), .pulse_a(pulse_a),
		.chan_a(channel_a_inhibit_in), .chan_b(channel_b_inhibit_in));
	initial forever #10 sys_clk = ~sys_clk;
	task chk(input logic [5:0] seen, input logic [5:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %b want %b", $time, seen, exp);
		end
	endtask
	task waitn(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task stop_test;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Hang guard
	initial begin
		#20us;
		error_cnt++;
		stop_test;
	end
	// Table, then hand-written cases
	initial begin
		waitn(4);
		chk(o, 6'b001010);
		reset = 0;
		for (int i = 0; i < 7; i++) begin
			{cmd_a, cmd_b, sw_run_request} = rows[i][6:4];
			waitn(FC + 3);
			chk(o, {rows[i][3:1], 1'b0, rows[i][0], ~rows[i][0]});
		end
		{cmd_a, cmd_b, sw_run_request} = 3'b111;
		waitn(FC + 3);
		pulse_a = 1;
		waitn(FC - 1);
		pulse_a = 0;
		waitn(3);
		chk(o, 6'b110001);
		cmd_b = 0;
		waitn(TC - 4);
		cmd_b = 1;
		waitn(FC + 3);
		chk(o, 6'b110001);
		cmd_b = 0;
		waitn(TC + FC + 10);
		chk(o, 6'b001101);
		cmd_b = 1;
		waitn(FC + 3);
		chk(o, 6'b001101);
		{cmd_a, cmd_b} = 2'b00;
		waitn(FC + 6);
		chk(o, 6'b001101);
		reset = 1;
		waitn(1);
		reset = 0;
		waitn(FC + 3);
		chk(o, 6'b001010);
		stop_test;
	end
endmodule // tim_monitor_bench
`default_nettype wire
